// ==== design/dcmc_config.sv ====
// decimation and control mode configuration, top module
// assumes the serial front end presents decoded register writes and reads
`timescale 1ns/1ns
module dcmc_config #(
    parameter int DEC_CODE_W = 3
) (
    // clock, reset, enable
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    // strap and mode pins
    input wire logic CTRL_MODE_STRAP,
    input wire logic MODE_SELECT_PIN_ZERO,
    input wire logic [1:0] MODE_SELECT_PWR,
    input wire logic [1:0] MODE_SELECT_FILTER,
    // register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [4:0] REG_CLK_DIV,
    input wire logic REG_INBUF_EN,
    output logic [7:0] REG_RDATA,
    output logic REG_WR_REJECT,
    // configuration out
    output logic REGISTER_MODE,
    output logic [1:0] FILTER_TYPE,
    output logic [18:0] DECIMATION_RATIO,
    output logic [4:0] CLK_DIV,
    output logic INPUT_PRECHARGE_EN,
    output logic MOD_TICK,
    output logic MOD_PHASE,
    output logic CHOP_PHASE,
    output logic CONFIG_VALID
);
    if (DEC_CODE_W < 1 || DEC_CODE_W > dcmc_pkg::FLT_DEC_W) begin : g_bad_code_w
        $error("DEC_CODE_W must be 1 to 3");
    end

    dcmc_mod_if mi ();

    dcmc_pkg::dcmc_state_t st_ff, nxt_st;
    logic regmode_ff, nxt_regmode;
    logic [7:0] filt_ff, nxt_filt;
    logic [7:0] s3lo_ff, nxt_s3lo;
    logic [dcmc_pkg::S3_HIGH_W-1:0] s3hi_ff, nxt_s3hi;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rej_ff, nxt_rej;
    logic [1:0] ftype_ff, nxt_ftype;
    logic [18:0] ratio_ff, nxt_ratio;
    logic [4:0] div_ff, nxt_div;
    logic pre_ff, nxt_pre;
    logic strap_pin0_ff, nxt_strap_pin0;
    logic [1:0] strap_pwr_ff, nxt_strap_pwr;
    logic [1:0] strap_flt_ff, nxt_strap_flt;
    logic chop_fast_ff;
    logic valid_ff, nxt_valid;
    logic tick_ff, phase_ff, chopo_ff;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function automatic logic [18:0] sinc3_ratio(input logic [12:0] v);
        logic [18:0] w;
        w = {6'h00, v} + 19'h0_0001;
        sinc3_ratio = 19'(w << dcmc_pkg::S3_SCALE_SHIFT);
    endfunction : sinc3_ratio

    function automatic logic [4:0] pwr_div(input logic [1:0] p);
        case (p)
            dcmc_pkg::DCMC_PWR_FAST: pwr_div = dcmc_pkg::DIV_FAST;
            dcmc_pkg::DCMC_PWR_MEDIAN: pwr_div = dcmc_pkg::DIV_MEDIAN;
            default: pwr_div = dcmc_pkg::DIV_LOW;
        endcase
    endfunction : pwr_div

    function automatic logic is_sinc3(input logic [1:0] t);
        is_sinc3 = (t == dcmc_pkg::FLT_TYPE_SINC3);
    endfunction : is_sinc3

    // ----------------------------------------
    // power-up capture and state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_regmode = regmode_ff;
        nxt_strap_pin0 = strap_pin0_ff;
        nxt_strap_pwr = strap_pwr_ff;
        nxt_strap_flt = strap_flt_ff;
        case (st_ff)
            dcmc_pkg::DCMC_ST_RESET: begin
                // strap caught once after reset release
                nxt_regmode = CTRL_MODE_STRAP;
                nxt_strap_pin0 = MODE_SELECT_PIN_ZERO;
                nxt_strap_pwr = MODE_SELECT_PWR;
                nxt_strap_flt = MODE_SELECT_FILTER;
                nxt_st = dcmc_pkg::DCMC_ST_STRAP;
            end
            dcmc_pkg::DCMC_ST_STRAP: nxt_st = dcmc_pkg::DCMC_ST_RUN;
            dcmc_pkg::DCMC_ST_RUN: nxt_st = dcmc_pkg::DCMC_ST_RUN;
            default: nxt_st = dcmc_pkg::DCMC_ST_RESET;
        endcase
        nxt_valid = (nxt_st == dcmc_pkg::DCMC_ST_RUN);
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            st_ff <= dcmc_pkg::DCMC_ST_RESET;
            valid_ff <= 1'b0;
            regmode_ff <= 1'b0;
            strap_pin0_ff <= 1'b0;
            strap_pwr_ff <= 2'b00;
            strap_flt_ff <= 2'b00;
        end else if (CE) begin
            st_ff <= nxt_st;
            valid_ff <= nxt_valid;
            regmode_ff <= nxt_regmode;
            strap_pin0_ff <= nxt_strap_pin0;
            strap_pwr_ff <= nxt_strap_pwr;
            strap_flt_ff <= nxt_strap_flt;
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic wr_ok;
    assign wr_ok = REG_WR && regmode_ff && (st_ff == dcmc_pkg::DCMC_ST_RUN);

    always_comb begin
        nxt_filt = filt_ff;
        nxt_s3lo = s3lo_ff;
        nxt_s3hi = s3hi_ff;
        nxt_rej = REG_WR && !wr_ok;
        nxt_rdata = rdata_ff;
        if (wr_ok) begin
            case (REG_ADDR)
                dcmc_pkg::REG_FILTER: nxt_filt = REG_WDATA;
                dcmc_pkg::REG_S3_LOW: nxt_s3lo = REG_WDATA;
                dcmc_pkg::REG_S3_HIGH: nxt_s3hi = REG_WDATA[dcmc_pkg::S3_HIGH_W-1:0];
                default: nxt_filt = filt_ff;
            endcase
        end
        // reads stay open in both modes
        if (REG_RD) begin
            case (REG_ADDR)
                dcmc_pkg::REG_FILTER: nxt_rdata = filt_ff;
                dcmc_pkg::REG_S3_LOW: nxt_rdata = s3lo_ff;
                dcmc_pkg::REG_S3_HIGH: nxt_rdata = {3'b000, s3hi_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            filt_ff <= dcmc_pkg::FILTER_RST;
            s3lo_ff <= dcmc_pkg::S3_LOW_RST;
            s3hi_ff <= dcmc_pkg::S3_HIGH_RST[dcmc_pkg::S3_HIGH_W-1:0];
            rdata_ff <= 8'h00;
            rej_ff <= 1'b0;
        end else if (CE) begin
            filt_ff <= nxt_filt;
            s3lo_ff <= nxt_s3lo;
            s3hi_ff <= nxt_s3hi;
            rdata_ff <= nxt_rdata;
            rej_ff <= nxt_rej;
        end
    end

    // ----------------------------------------
    // effective configuration
    // ----------------------------------------
    logic [12:0] s3_val;
    logic [DEC_CODE_W-1:0] dec_code;
    assign s3_val = {s3hi_ff, s3lo_ff};
    assign dec_code = filt_ff[dcmc_pkg::FLT_DEC_LSB +: DEC_CODE_W];

    always_comb begin
        nxt_ftype = ftype_ff;
        nxt_ratio = ratio_ff;
        nxt_div = div_ff;
        nxt_pre = pre_ff;
        if (st_ff == dcmc_pkg::DCMC_ST_RUN) begin
            if (regmode_ff) begin
                // full access: any filter, rate, divide and buffer choice
                nxt_ftype = filt_ff[dcmc_pkg::FLT_TYPE_LSB +: dcmc_pkg::FLT_TYPE_W];
                nxt_div = REG_CLK_DIV;
                nxt_pre = REG_INBUF_EN;
                if (is_sinc3(nxt_ftype))
                    nxt_ratio = sinc3_ratio(s3_val);
                else
                    nxt_ratio = 19'(dcmc_pkg::RATIO_BASE << dec_code);
            end else begin
                nxt_ftype = strap_flt_ff;
                nxt_div = pwr_div(strap_pwr_ff);
                nxt_pre = 1'b1;
                nxt_ratio = strap_pin0_ff ? dcmc_pkg::RATIO_X64
                                          : dcmc_pkg::RATIO_BASE;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ftype_ff <= 2'b00;
            ratio_ff <= dcmc_pkg::RATIO_BASE;
            div_ff <= dcmc_pkg::DIV_LOW;
            pre_ff <= 1'b0;
            chop_fast_ff <= 1'b0;
            tick_ff <= 1'b0;
            phase_ff <= 1'b0;
            chopo_ff <= 1'b0;
        end else if (CE) begin
            ftype_ff <= nxt_ftype;
            ratio_ff <= nxt_ratio;
            div_ff <= nxt_div;
            pre_ff <= nxt_pre;
            chop_fast_ff <= regmode_ff && filt_ff[dcmc_pkg::FLT_CHOP_BIT];
            tick_ff <= mi.mod_tick;
            phase_ff <= mi.mod_phase;
            chopo_ff <= mi.chop_phase;
        end
    end

    // ----------------------------------------
    // modulator timing
    // ----------------------------------------
    assign mi.clk_div = div_ff;
    assign mi.chop_div = chop_fast_ff ? dcmc_pkg::CHOP_DIV_FAST
                                      : dcmc_pkg::CHOP_DIV_SLOW;
    assign mi.run = (st_ff == dcmc_pkg::DCMC_ST_RUN);

    dcmc_mod_timer u_timer (
        .CLOCK(CLOCK),
        .NRST(NRST),
        .CE(CE),
        .mi(mi)
    );

    assign REG_RDATA = rdata_ff;
    assign REG_WR_REJECT = rej_ff;
    assign REGISTER_MODE = regmode_ff;
    assign FILTER_TYPE = ftype_ff;
    assign DECIMATION_RATIO = ratio_ff;
    assign CLK_DIV = div_ff;
    assign INPUT_PRECHARGE_EN = pre_ff;
    assign MOD_TICK = tick_ff;
    assign MOD_PHASE = phase_ff;
    assign CHOP_PHASE = chopo_ff;
    assign CONFIG_VALID = valid_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_strap_no_write: assert property (@(posedge CLOCK) disable iff (!NRST)
        CE && REG_WR && !regmode_ff |=> rej_ff && $stable(filt_ff))
        else $error("write accepted in strapped mode");
    a_strap_ratio: assert property (@(posedge CLOCK) disable iff (!NRST)
        CE && !regmode_ff && st_ff == dcmc_pkg::DCMC_ST_RUN |=>
        ratio_ff == (strap_pin0_ff ? 19'h0_0040 : 19'h0_0020))
        else $error("strapped ratio not from mode pin");
    a_strap_set: assert property (@(posedge CLOCK) disable iff (!NRST)
        CE && !regmode_ff && st_ff == dcmc_pkg::DCMC_ST_RUN |=>
        ratio_ff inside {19'h0_0020, 19'h0_0040})
        else $error("strapped ratio outside 32 or 64");
    a_sinc3_ratio: assert property (@(posedge CLOCK) disable iff (!NRST)
        $past(CE) && regmode_ff && mi.run && ftype_ff == 2'b01 && $stable(s3_val) |->
        ratio_ff == 19'((19'(s3_val) + 19'h0_0001) * 19'h0_0020))
        else $error("sinc3 ratio not (value+1)*32");
    a_sinc3_join: assert property (@(posedge CLOCK) disable iff (!NRST)
        CE && wr_ok && REG_ADDR == dcmc_pkg::REG_S3_HIGH |=>
        s3_val[12:8] == $past(REG_WDATA[4:0]))
        else $error("high sinc3 bits not stored");
    a_regmode_ratio: assert property (@(posedge CLOCK) disable iff (!NRST)
        $past(CE) && regmode_ff && mi.run && ftype_ff != 2'b01 && $stable(filt_ff) |->
        ratio_ff == 19'(19'h0_0020 << dec_code))
        else $error("filter register ratio wrong");
    a_strap_div: assert property (@(posedge CLOCK) disable iff (!NRST)
        CE && !regmode_ff && st_ff == dcmc_pkg::DCMC_ST_RUN &&
        strap_pwr_ff == 2'b11 |=> div_ff == 5'h02)
        else $error("fast mode divide not 2");
    a_strap_prechg: assert property (@(posedge CLOCK) disable iff (!NRST)
        CE && !regmode_ff && st_ff == dcmc_pkg::DCMC_ST_RUN |=> pre_ff)
        else $error("precharge buffer off in strapped mode");
    a_chop_slow: assert property (@(posedge CLOCK) disable iff (!NRST)
        !regmode_ff && st_ff == dcmc_pkg::DCMC_ST_RUN |-> !chop_fast_ff)
        else $error("fast chop in strapped mode");
    a_mode_fixed: assert property (@(posedge CLOCK) disable iff (!NRST)
        st_ff == dcmc_pkg::DCMC_ST_RUN |=> $stable(regmode_ff))
        else $error("control mode changed after power-up");
    c_strap_64: cover property (@(posedge CLOCK) disable iff (!NRST)
        !regmode_ff && ratio_ff == 19'h0_0040);
    c_sinc3: cover property (@(posedge CLOCK) disable iff (!NRST)
        regmode_ff && ftype_ff == 2'b01 && ratio_ff == 19'h0_00c0);
    c_reject: cover property (@(posedge CLOCK) disable iff (!NRST) rej_ff);
    c_tick: cover property (@(posedge CLOCK) disable iff (!NRST) tick_ff && chop_fast_ff);
endmodule : dcmc_config

// ==== design/dcmc_mod_if.sv ====
// carrier between the top and the modulator clock and chop timing module
// assumes one clock domain
`timescale 1ns/1ns
interface dcmc_mod_if;
    logic [4:0] clk_div;
    logic [5:0] chop_div;
    logic run;
    logic mod_tick;
    logic mod_phase;
    logic chop_phase;
    modport ctrl (output clk_div, output chop_div, output run,
                  input mod_tick, input mod_phase, input chop_phase);
    modport timing (input clk_div, input chop_div, input run,
                    output mod_tick, output mod_phase, output chop_phase);
endinterface : dcmc_mod_if

// ==== design/dcmc_mod_timer.sv ====
// modulator clock divider and chop phase generator
// assumes divide and chop values are held steady while run is high
`timescale 1ns/1ns
module dcmc_mod_timer (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    // link to the top
    dcmc_mod_if.timing mi
);
    logic [4:0] div_cnt_ff, nxt_div_cnt;
    logic [5:0] chop_cnt_ff, nxt_chop_cnt;
    logic phase_ff, nxt_phase;
    logic tick_ff, nxt_tick;
    logic chop_ff, nxt_chop;

    // ----------------------------------------
    // half periods of the modulator clock
    // ----------------------------------------
    always_comb begin
        nxt_div_cnt = div_cnt_ff;
        nxt_phase = phase_ff;
        nxt_tick = 1'b0;
        nxt_chop_cnt = chop_cnt_ff;
        nxt_chop = chop_ff;
        if (!mi.run) begin
            nxt_div_cnt = '0;
            nxt_phase = 1'b0;
            nxt_chop_cnt = '0;
            nxt_chop = 1'b0;
        end else if (div_cnt_ff >= 5'((mi.clk_div >> 1) - 5'h01)) begin
            // sampling on both edges: every half period toggles the phase
            nxt_div_cnt = '0;
            nxt_phase = ~phase_ff;
            if (phase_ff) begin
                // one result per full modulator period
                nxt_tick = 1'b1;
                // at or past the end: a shorter chop divide never wraps the count
                if (chop_cnt_ff >= 6'((mi.chop_div >> 1) - 6'h01)) begin
                    nxt_chop_cnt = '0;
                    nxt_chop = ~chop_ff;
                end else begin
                    nxt_chop_cnt = chop_cnt_ff + 6'h01;
                end
            end
        end else begin
            nxt_div_cnt = div_cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            div_cnt_ff <= '0;
            chop_cnt_ff <= '0;
            phase_ff <= 1'b0;
            tick_ff <= 1'b0;
            chop_ff <= 1'b0;
        end else if (CE) begin
            div_cnt_ff <= nxt_div_cnt;
            chop_cnt_ff <= nxt_chop_cnt;
            phase_ff <= nxt_phase;
            tick_ff <= nxt_tick;
            chop_ff <= nxt_chop;
        end
    end

    assign mi.mod_tick = tick_ff;
    assign mi.mod_phase = phase_ff;
    assign mi.chop_phase = chop_ff;

    a_tick_on_fall: assert property (@(posedge CLOCK) disable iff (!NRST)
        $past(CE) && tick_ff |-> $past(phase_ff) && !phase_ff)
        else $error("result tick not at end of modulator period");
endmodule : dcmc_mod_timer

// ==== design/dcmc_pkg.sv ====
// package for the decimation and control mode configuration block
// assumes a register write/read port supplied by the serial front end
package dcmc_pkg;
    // register offsets
    localparam logic [7:0] REG_FILTER = 8'h19;
    localparam logic [7:0] REG_S3_LOW = 8'h1a;
    localparam logic [7:0] REG_S3_HIGH = 8'h1b;
    // filter register field layout
    localparam int FLT_DEC_LSB = 0;
    localparam int FLT_DEC_W = 3;
    localparam int FLT_TYPE_LSB = 4;
    localparam int FLT_TYPE_W = 2;
    localparam int FLT_CHOP_BIT = 7;
    localparam logic [1:0] FLT_TYPE_SINC3 = 2'b01;
    // reset values
    localparam logic [7:0] FILTER_RST = 8'h00;
    localparam logic [7:0] S3_LOW_RST = 8'h00;
    localparam logic [7:0] S3_HIGH_RST = 8'h00;
    // sinc3 value width and scale
    localparam int S3_W = 13;
    localparam int S3_HIGH_W = 5;
    localparam int S3_SCALE_SHIFT = 5;
    localparam int RATIO_W = 19;
    // base decimation ratio and strapped choices
    localparam logic [18:0] RATIO_BASE = 19'h0_0020;
    localparam logic [18:0] RATIO_X64 = 19'h0_0040;
    // modulator clock divide codes
    localparam logic [4:0] DIV_FAST = 5'h02;
    localparam logic [4:0] DIV_MEDIAN = 5'h04;
    localparam logic [4:0] DIV_LOW = 5'h10;
    // chop divides
    localparam logic [5:0] CHOP_DIV_SLOW = 6'h20;
    localparam logic [5:0] CHOP_DIV_FAST = 6'h08;
    typedef enum logic [1:0] {
        DCMC_PWR_LOW = 2'b00,
        DCMC_PWR_MEDIAN = 2'b01,
        DCMC_PWR_FAST = 2'b11
    } dcmc_pwr_t;
    typedef enum logic [1:0] {
        DCMC_ST_RESET = 2'b00,
        DCMC_ST_STRAP = 2'b01,
        DCMC_ST_RUN = 2'b11
    } dcmc_state_t;
endpackage : dcmc_pkg

// ==== test/dcmc_host.sv ====
// host model: issues register writes and reads on the block's register port
// assumes the caller starts no access before configuration is valid
`timescale 1ns/1ns
module dcmc_host (
    // clock
    input wire logic CLOCK,
    // register port toward the block
    output logic REG_WR,
    output logic REG_RD,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    // answers from the block
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_WR_REJECT
);
    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    initial begin
        REG_WR = 1'h0;
        REG_RD = 1'h0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    // address is inverted after each access, and data after a write, so stale values never look valid
    task wr(input logic [7:0] a, input logic [7:0] d, output logic rej);
        @(negedge CLOCK);
        REG_WR = 1'h1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge CLOCK);
        rej = REG_WR_REJECT;
        REG_WR = 1'h0;
        REG_ADDR = ~a;
        REG_WDATA = ~d;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge CLOCK);
        REG_RD = 1'h1;
        REG_ADDR = a;
        @(negedge CLOCK);
        d = REG_RDATA;
        REG_RD = 1'h0;
        REG_ADDR = ~a;
    endtask : rd
endmodule : dcmc_host

// ==== test/testbench.sv ====
// self-checking bench for the decimation and control mode block
// assumes dcmc_host drives the register port; inputs change at falling edges
`timescale 1ns/1ns
module testbench;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic strap = 1'h1;
    logic pin0 = 1'h0;
    logic [1:0] pwr = 2'h3;
    logic [1:0] flt = 2'h0;
    logic [4:0] reg_div = 5'h02;
    logic inbuf = 1'h0;
    logic ce = 1'h1;
    logic ph;
    logic reg_wr, reg_rd, reg_wr_reject, register_mode, precharge;
    logic mod_tick, mod_phase, chop_phase, config_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic [1:0] filter_type;
    logic [18:0] ratio;
    logic [4:0] clk_div;
    logic rej;
    int fails = 0;
    int total_checks = 0;
    int n;
    logic [1:0] pw_t [3] = '{2'h3, 2'h1, 2'h0};
    logic [4:0] dv_t [3] = '{5'h02, 5'h04, 5'h10};

    always #2 clock = ~clock;

    // ----------------------------------------
    // design and host
    // ----------------------------------------
    dcmc_config i_dut (.CLOCK(clock), .NRST(nrst), .CE(ce), .CTRL_MODE_STRAP(strap),
        .MODE_SELECT_PIN_ZERO(pin0), .MODE_SELECT_PWR(pwr), .MODE_SELECT_FILTER(flt),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_CLK_DIV(reg_div), .REG_INBUF_EN(inbuf), .REG_RDATA(reg_rdata),
        .REG_WR_REJECT(reg_wr_reject), .REGISTER_MODE(register_mode),
        .FILTER_TYPE(filter_type), .DECIMATION_RATIO(ratio), .CLK_DIV(clk_div),
        .INPUT_PRECHARGE_EN(precharge), .MOD_TICK(mod_tick), .MOD_PHASE(mod_phase),
        .CHOP_PHASE(chop_phase), .CONFIG_VALID(config_valid));

    dcmc_host i_host (.CLOCK(clock), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_WR_REJECT(reg_wr_reject));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task restart(input logic s, input logic p0, input logic [1:0] pw);
        @(negedge clock);
        nrst = 1'h0;
        strap = s;
        pin0 = p0;
        pwr = pw;
        repeat (2) @(negedge clock);
        chk(config_valid, 1'h0);
        nrst = 1'h1;
        repeat (4) @(negedge clock);
        chk(config_valid, 1'h1);
    endtask : restart

    task settle;
        repeat (2) @(negedge clock);
    endtask : settle

    // cycles between ticks, or between chop edges after skipping two edges
    task period(input logic chop, output int cnt);
        logic c;
        cnt = 0;
        if (!chop) begin
            while (mod_tick !== 1'h1 && cnt < 1000) begin
                @(negedge clock);
                cnt++;
            end
            cnt = 0;
            do begin
                @(negedge clock);
                cnt++;
            end while (mod_tick !== 1'h1 && cnt < 1000);
        end else begin
            repeat (3) begin
                c = chop_phase;
                cnt = 0;
                while (chop_phase === c && cnt < 5000) begin
                    @(negedge clock);
                    cnt++;
                end
            end
        end
    endtask : period

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        restart(1'h1, 1'h0, 2'h3);
        chk(register_mode, 1'h1);
        chk(clk_div, 5'h02);
        chk(precharge, 1'h0);
        inbuf = 1'h1;
        settle();
        chk(precharge, 1'h1);
        for (int a = 8'h19; a <= 8'h1c; a++) begin
            i_host.rd(8'(a), rd);
            chk(rd, 8'h00);
        end
        for (int c = 0; c < 6; c++) begin
            i_host.wr(8'(c), 8'h00, rej);
            i_host.wr(8'h19, 8'(c), rej);
            settle();
            chk(ratio, 32'(32 << c));
            chk(rej, 1'h0);
        end
        i_host.wr(8'h1a, 8'h05, rej);
        i_host.wr(8'h19, 8'h10, rej);
        settle();
        chk(filter_type, 2'h1);
        chk(ratio, 32'h0000_00c0);
        i_host.wr(8'h1b, 8'hff, rej);
        settle();
        chk(ratio, 32'h0003_e0c0);
        i_host.rd(8'h1b, rd);
        chk(rd, 8'h1f);
        i_host.rd(8'h1a, rd);
        chk(rd, 8'h05);
        i_host.wr(8'h1a, 8'hff, rej);
        settle();
        chk(ratio, 32'h0004_0000);
        i_host.wr(8'h1b, 8'h00, rej);
        settle();
        chk(ratio, 32'h0000_2000);
        reg_div = 5'h04;
        settle();
        chk(clk_div, 5'h04);
        // enable low freezes the modulator clock; it would toggle within two cycles
        ce = 1'h0;
        ph = mod_phase;
        repeat (2) @(negedge clock);
        chk(mod_phase, ph);
        ce = 1'h1;
        repeat (2) @(negedge clock);
        chk(mod_phase, !ph);
        period(1'h0, n);
        chk(n, 32'h0000_0004);
        period(1'h1, n);
        chk(n, 32'h0000_0040);
        i_host.wr(8'h19, 8'h80, rej);
        settle();
        period(1'h1, n);
        chk(n, 32'h0000_0010);
        strap = 1'h0;
        flt = 2'h2;
        settle();
        chk(register_mode, 1'h1);
        for (int i = 0; i < 3; i++) begin
            restart(1'h0, 1'(i), pw_t[i]);
            chk(register_mode, 1'h0);
            chk(clk_div, dv_t[i]);
            chk(ratio, (i % 2) ? 32'h0000_0040 : 32'h0000_0020);
            chk(precharge, 1'h1);
            chk(filter_type, flt);
            i_host.wr(8'h19, 8'h85, rej);
            chk(rej, 1'h1);
            settle();
            chk(ratio, (i % 2) ? 32'h0000_0040 : 32'h0000_0020);
            i_host.rd(8'h19, rd);
            chk(rd, 8'h00);
            period(1'h1, n);
            chk(n, 32'(16 * dv_t[i]));
        end
        stop_test();
    end

    initial begin
        #200000;
        fails++;
        stop_test();
    end
endmodule : testbench
